// ---- hw/sap_top.sv ----
// Serial audio master port: bit clock, frame strobe, 16-bit word in and out
`timescale 1ns/1ps

module sap_top
   import sap_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic        enable_i,
   input  wire logic        mode_pcm_i,
   input  wire logic        pcm_long_i,
   input  wire logic        rate_16k_i,
   input  wire logic [15:0] tx_sample_i,
   output logic             tx_taken_o,
   output logic [15:0]      rx_sample_o,
   output logic             rx_valid_o,
   output logic             bclk_o,
   output logic             frame_align_strobe_o,
   output logic             txd_o,
   input  wire logic        rxd_i
);

   function automatic logic strobe_fn(input logic [4:0] bit_n, input logic pcm,
                                      input logic lng);
      if (pcm)
         strobe_fn = (32'(bit_n) < (lng ? PCM_LONG : PCM_SHORT));
      else
         strobe_fn = (32'(bit_n) < NORM_HIGH);
   endfunction : strobe_fn

   logic [1:0]  rst_sync_reg;
   logic        rst_n;
   logic [2:0]  rxd_sync_reg;
   logic        rxd_filt_reg;
   logic [6:0]  half_cnt_reg;
   logic        bclk_reg;
   logic [4:0]  bit_cnt_reg;
   logic        strobe_reg;
   logic [15:0] tx_shift_reg;
   logic        txd_reg;
   logic        tx_taken_reg;
   logic [15:0] rx_shift_reg;
   logic [15:0] rx_word_reg;
   logic        rx_valid_reg;

   wire  logic [6:0]  half_max = rate_16k_i ? HALF_HI_CYC : HALF_LO_CYC;
   wire  logic        half_end = (half_cnt_reg >= half_max);
   wire  logic        fall_evt = enable_i && half_end && bclk_reg;
   wire  logic        rise_evt = enable_i && half_end && !bclk_reg;
   wire  logic [4:0]  bit_next = bit_cnt_reg + 5'h01;
   wire  logic        in_word  = (bit_cnt_reg <= WORD_LAST);
   wire  logic [15:0] rx_next  = {rx_shift_reg[14:0], rxd_filt_reg};

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // Three stages; value accepted only when the last two agree
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxd_sync_reg <= 3'h0;
         rxd_filt_reg <= 1'b0;
      end
      else
      begin
         rxd_sync_reg <= {rxd_sync_reg[1:0], rxd_i};
         if (rxd_sync_reg[2] == rxd_sync_reg[1])
            rxd_filt_reg <= rxd_sync_reg[2];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         half_cnt_reg <= 7'h00;
         bclk_reg     <= 1'b0;
      end
      else if (!enable_i)
      begin
         half_cnt_reg <= 7'h00;
         bclk_reg     <= 1'b0;
      end
      else if (half_end)
      begin
         half_cnt_reg <= 7'h00;
         bclk_reg     <= !bclk_reg;
      end
      else
         half_cnt_reg <= half_cnt_reg + 7'h01;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt_reg  <= BIT_LAST;
         strobe_reg   <= 1'b0;
         tx_shift_reg <= WORD_RST;
         txd_reg      <= 1'b0;
         tx_taken_reg <= 1'b0;
      end
      else
      begin
         tx_taken_reg <= 1'b0;
         if (!enable_i)
         begin
            bit_cnt_reg <= BIT_LAST;
            strobe_reg  <= 1'b0;
            txd_reg     <= 1'b0;
         end
         else if (fall_evt)
         begin
            bit_cnt_reg <= bit_next;
            strobe_reg  <= strobe_fn(bit_next, mode_pcm_i, pcm_long_i);
            if (bit_next == 5'h00)
            begin
               tx_shift_reg <= {tx_sample_i[14:0], 1'b0};
               txd_reg      <= tx_sample_i[15];
               tx_taken_reg <= 1'b1;
            end
            else if (bit_next <= WORD_LAST)
            begin
               tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
               txd_reg      <= tx_shift_reg[15];
            end
            else
               txd_reg <= 1'b0;
         end
      end
   end

   // capture on rising edge, MSB first
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_shift_reg <= WORD_RST;
         rx_word_reg  <= WORD_RST;
         rx_valid_reg <= 1'b0;
      end
      else
      begin
         rx_valid_reg <= 1'b0;
         if (rise_evt && in_word)
         begin
            rx_shift_reg <= rx_next;
            if (bit_cnt_reg == WORD_LAST)
            begin
               rx_word_reg  <= rx_next;
               rx_valid_reg <= 1'b1;
            end
         end
      end
   end

   assign bclk_o               = bclk_reg;
   assign frame_align_strobe_o = strobe_reg;
   assign txd_o                = txd_reg;
   assign tx_taken_o           = tx_taken_reg;
   assign rx_sample_o          = rx_word_reg;
   assign rx_valid_o           = rx_valid_reg;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   a_pcm_strobe_len: assert property (
      (enable_i && mode_pcm_i && frame_align_strobe_o)
         |-> (bit_cnt_reg < (pcm_long_i ? 5'h02 : 5'h01)))
      else $error("PCM strobe too long");
   a_norm_strobe_half: assert property (
      (enable_i && !mode_pcm_i && !$rose(enable_i) && !$changed(mode_pcm_i)
         && $past(fall_evt)) |-> (frame_align_strobe_o == (bit_cnt_reg < 5'h10)))
      else $error("Normal strobe not half duty");
   a_bclk_runs: assert property (
      (enable_i && $changed(bclk_o)) |-> ##[1:80] (!enable_i || $changed(bclk_o)))
      else $error("Bit clock stalled");
   a_frame_count: assert property (
      fall_evt |=> (bit_cnt_reg == $past(bit_next)))
      else $error("Bit counter skipped");
   a_tx_load_msb: assert property (
      tx_taken_o |-> (txd_o == $past(tx_sample_i[15]) && bit_cnt_reg == 5'h00))
      else $error("Word not sent MSB first at frame start");
   a_rx_word_end: assert property (
      rx_valid_o |-> (bit_cnt_reg == WORD_LAST && rx_sample_o == rx_shift_reg))
      else $error("Receive word not complete");
   a_tx_on_fall: assert property (
      ($changed(txd_o) || $changed(frame_align_strobe_o)) |-> !bclk_o)
      else $error("Launch not on falling edge");
   a_rate_half: assert property (
      rise_evt |-> (half_cnt_reg == (rate_16k_i ? HALF_HI_CYC : HALF_LO_CYC)))
      else $error("Half period wrong for rate");
   a_idle_quiet: assert property (
      (!enable_i && !$past(enable_i)) |-> (!bclk_o && !frame_align_strobe_o && !txd_o))
      else $error("Lines not quiet while stopped");
   a_strobe_at_start: assert property (
      tx_taken_o |-> frame_align_strobe_o)
      else $error("Strobe low at frame start");
   a_txd_tail_low: assert property (
      (bit_cnt_reg > WORD_LAST) |-> !txd_o)
      else $error("Data after the word");

endmodule : sap_top

// ---- hw/sap_pkg.sv ----
// Constants for the serial audio master port
package sap_pkg;
   localparam int          CLK_HZ       = 40_000_000;
   localparam int          RATE_LO_HZ   = 8_000;
   localparam int          RATE_HI_HZ   = 16_000;
   localparam int          FRAME_BITS   = 32;
   localparam int          WORD_BITS    = 16;
   localparam int          NORM_HIGH    = 16;
   localparam int          PCM_SHORT    = 1;
   localparam int          PCM_LONG     = 2;
   // Half bit-clock periods, rounded down; the frame rate is therefore slightly fast
   localparam logic [6:0]  HALF_LO_CYC  = 7'(CLK_HZ / (2 * FRAME_BITS * RATE_LO_HZ) - 1);
   localparam logic [6:0]  HALF_HI_CYC  = 7'(CLK_HZ / (2 * FRAME_BITS * RATE_HI_HZ) - 1);
   localparam logic [4:0]  BIT_LAST     = 5'h1F;
   localparam logic [4:0]  WORD_LAST    = 5'h0F;
   localparam logic [15:0] WORD_RST     = 16'h0000;
endpackage : sap_pkg

// ---- verification/sap_codec_model.sv ----
// Codec model that drives the receive line
`timescale 1ns/1ps
module sap_codec_model
(
   input  wire logic        bclk_i,
   input  wire logic        strobe_i,
   input  wire logic [15:0] word_i,
   output logic             rxd_o
);
   logic [4:0] cnt_reg;
   logic       prev_reg;
   initial
   begin
      cnt_reg  = 5'h00;
      prev_reg = 1'b0;
      rxd_o    = 1'b0;
   end
   always @(negedge bclk_i)
   begin
      #1;
      cnt_reg  = (strobe_i && !prev_reg) ? 5'h00 : cnt_reg + 5'h01;
      // No pull on the line, so idle bits toggle
      rxd_o    = (cnt_reg < 5'h10) ? word_i[4'hF - cnt_reg[3:0]] : !rxd_o;
   end
   // Strobe taken at the rise, so a stop right after a frame start leaves no stale level
   always @(posedge bclk_i)
      prev_reg = strobe_i;
endmodule : sap_codec_model

// ---- verification/tb.sv ----
// Testbench for the serial audio master port
`timescale 1ns/1ps
module tb;
   import sap_pkg::*;
   logic        clk, rstn, en, pcm, lng, r16, taken, rxv, bclk, strb, txd, rxd;
   logic [15:0] txw, rxs, cw, rxw;
   int          num_errors, num_checks, cyc;
   sap_top DUT (.clk_sys_i(clk), .resetn_i(rstn), .enable_i(en), .mode_pcm_i(pcm),
      .pcm_long_i(lng), .rate_16k_i(r16), .tx_sample_i(txw), .tx_taken_o(taken),
      .rx_sample_o(rxs), .rx_valid_o(rxv), .bclk_o(bclk), .frame_align_strobe_o(strb),
      .txd_o(txd), .rxd_i(rxd));
   sap_codec_model codec (.bclk_i(bclk), .strobe_i(strb), .word_i(cw), .rxd_o(rxd));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // Steps the clock until the bit clock reaches v, catching received words
   task automatic wait_bclk(input logic v);
      int n;
      n = 0;
      while (bclk !== v && n < 400)
      begin
         @(posedge clk) #1;
         n++;
         cyc++;
         if (rxv === 1'b1)
            rxw = rxs;
      end
      chk("bit clock", v, bclk);
   endtask : wait_bclk
   task automatic run_frame(input logic p, l, r, input logic [15:0] t, c, input int hi);
      logic [31:0] sb, db;
      int          half;
      {pcm, lng, r16, txw, cw} = {p, l, r, t, c};
      en = 1'b1;
      rxw = ~c;
      half = r ? int'(HALF_HI_CYC) + 1 : int'(HALF_LO_CYC) + 1;
      cyc = 0;
      while (taken !== 1'b1 && cyc < 400)
      begin
         @(posedge clk) #1;
         cyc++;
      end
      chk("word taken", 1, taken);
      cyc = 0;
      for (int i = 31; i >= 0; i--)
      begin
         wait_bclk(1'b1);
         sb[i] = strb;
         db[i] = txd;
         wait_bclk(1'b0);
      end
      chk("frame cycles", 64 * half, cyc);
      chk("next word taken", 1, taken);
      chk("strobe", ~(32'hFFFFFFFF >> hi), sb);
      chk("txd", {t, 16'h0000}, db);
      chk("rx word", c, rxw);
      en = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("idle lines", 0, {bclk, strb, txd});
   endtask : run_frame
   task automatic test_pcm_short;
      run_frame(1'b1, 1'b0, 1'b1, 16'h8001, 16'hA5C3, 1);
      $display("test pcm short done");
   endtask : test_pcm_short
   task automatic test_pcm_long;
      run_frame(1'b1, 1'b1, 1'b0, 16'h7FFE, 16'h8000, 2);
      $display("test pcm long done");
   endtask : test_pcm_long
   task automatic test_normal;
      run_frame(1'b0, 1'b1, 1'b1, 16'hC33C, 16'h7FFF, 16);
      $display("test normal done");
   endtask : test_normal
   initial
   begin
      {rstn, en, pcm, lng, r16, txw, cw, rxw} = '0;
      num_errors = 0;
      num_checks = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      test_pcm_short;
      test_pcm_long;
      test_normal;
      stop_test;
   end
   initial
   begin
      #1000000;
      num_errors++;
      stop_test;
   end
endmodule : tb
